// ==== verilog/src_stop_ctrl.sv ====
// src_stop_ctrl: stop method selection and recovery sequencing.
// assumes pins are synchronous-ish levels, an apb master and a motion
// engine that reports atRest and a hardware drive cutoff level.
//
// How it works
// - normal stop: decelerate along a profile while position control holds.
// - emergency-class stop: abort profile, servo off, cut motor power at once.
// - pause, servo-off, emergency stop and unlisted errors use controlled deceleration.
// - hold, cancel, stop and abort program commands decelerate to a stop.
// - the thirteen listed error codes take the immediate servo-off path.
// - system-down errors F00 through FBF also take immediate servo-off.
// - hardware cutoff during an emergency deceleration aborts the profile.
// - with port 14 selected, each rising edge requests drive-source recovery.
// - a host command requests drive-source recovery the same way.
// - with port 5 selected, each rising edge requests operation-pause reset.
// - emergency stop in automatic operation cleared with continue type: wait for pause reset, then resume.
// - deadman stop cleared with continue type: resume only on pause reset.
// - with port 6 selected, low pauses in automatic operation; after high again, pause reset resumes.
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module src_stop_ctrl (
	// clock and reset
	input  wire logic                      clk_sys,
	input  wire logic                      rst_n,
	// apb slave
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [7:0]                paddr,
	input  wire logic [31:0]               pwdata,
	output logic                           pready,
	output logic                           pslverr,
	output logic [31:0]                    prdata,
	// operator input ports and machine levels
	input  wire logic                      inPort14,
	input  wire logic                      inPort5,
	input  wire logic                      inPort6,
	input  wire logic                      emgStopIn,
	input  wire logic                      deadmanOk,
	input  wire logic                      autoMode,
	// motion engine and power stage
	input  wire logic                      atRest,
	input  wire logic                      hwCutoff,
	input  wire logic                      errValid,
	input  wire logic [src_pkg::ERR_W-1:0] errCode,
	// control outputs
	output logic                           decelActive,
	output logic                           servoOn,
	output logic                           drivePowerEn,
	output logic                           profileAbort,
	output logic                           opPaused,
	output logic                           opRunning,
	output logic                           irq
);
	src_pkg::src_state_t stateReg;
	src_pkg::src_state_t stateNext;

	logic [7:0]              cfgReg;
	logic [src_pkg::IRQ_W-1:0] irqStatReg;
	logic [src_pkg::IRQ_W-1:0] irqMaskReg;
	logic [src_pkg::ERR_W-1:0] lastErrReg;
	logic                    resumableReg;
	logic                    resumableNext;
	logic                    emgPrev;
	logic                    dmPrev;

	logic                    accWr;
	logic [8:0]              cmd;
	logic                    p14Rise;
	logic                    p5Rise;
	logic                    p6Lvl;
	logic                    errImm;
	logic                    errDec;
	logic                    drvRecReq;
	logic                    pauseRstReq;
	logic                    emgRise;
	logic                    dmFall;
	logic                    p6Fall;
	logic                    p6Prev;
	logic                    anyCause;
	logic                    decelEvt;
	logic                    contEvt;
	logic [src_pkg::IRQ_W-1:0] irqEvt;

	// pin synchronisers; unselected ports never raise a request
	src_edge_sync uSync14 (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.pinIn   (inPort14),
		.enable  (cfgReg[src_pkg::CFG_P14_EN]),
		.level   (),
		.rise    (p14Rise)
	);
	src_edge_sync uSync5 (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.pinIn   (inPort5),
		.enable  (cfgReg[src_pkg::CFG_P5_EN]),
		.level   (),
		.rise    (p5Rise)
	);
	src_edge_sync uSync6 (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.pinIn   (inPort6),
		.enable  (1'b0),
		.level   (p6Lvl),
		.rise    ()
	);

	// error sorting into the two stop methods
	src_err_class uErr (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.errValid (errValid),
		.errCode  (errCode),
		.immStop  (errImm),
		.decStop  (errDec)
	);

	// apb write strobe at the completing access edge
	assign accWr = psel & penable & pready & pwrite;

	// host command pulses, one cycle each
	assign cmd = (accWr && paddr == src_pkg::OFS_CMD) ? pwdata[8:0] : 9'h000;

	// recovery requests from pins or host share one path
	assign drvRecReq = p14Rise | cmd[src_pkg::CMD_DRV_REC];
	assign pauseRstReq = p5Rise | cmd[src_pkg::CMD_PAUSE_RST];

	// edge history of the machine levels
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			emgPrev <= 1'b0;
			dmPrev <= 1'b1;
			p6Prev <= 1'b1;
		end else begin
			emgPrev <= emgStopIn;
			dmPrev <= deadmanOk;
			p6Prev <= p6Lvl;
		end
	end

	assign emgRise = emgStopIn & ~emgPrev;
	assign dmFall = autoMode & dmPrev & ~deadmanOk;
	assign p6Fall = cfgReg[src_pkg::CFG_P6_EN] & autoMode & p6Prev & ~p6Lvl;

	// any level that still holds the axis stopped
	assign anyCause = emgStopIn | (autoMode & ~deadmanOk)
		| (cfgReg[src_pkg::CFG_P6_EN] & ~p6Lvl);

	// everything that asks for a controlled deceleration
	assign decelEvt = cmd[src_pkg::CMD_PAUSE] | cmd[src_pkg::CMD_SERVO_OFF]
		| emgRise | errDec | dmFall | p6Fall
		| cmd[src_pkg::CMD_HOLD] | cmd[src_pkg::CMD_CANCEL_PROGRAM]
		| cmd[src_pkg::CMD_STOP] | cmd[src_pkg::CMD_ABORT_PROGRAM];

	// stops after which the interrupted operation may continue
	assign contEvt = (emgRise & autoMode
			& cfgReg[src_pkg::CFG_EMG_LSB +: 2] == src_pkg::RECOVER_CONT)
		| (dmFall & cfgReg[src_pkg::CFG_DMS_LSB +: 2] == src_pkg::RECOVER_CONT)
		| p6Fall
		| cmd[src_pkg::CMD_PAUSE] | cmd[src_pkg::CMD_HOLD];

	// next state and the continue decision
	always_comb begin
		stateNext = stateReg;
		resumableNext = resumableReg;
		if (decelEvt)
			resumableNext = contEvt & ~(errDec | cmd[src_pkg::CMD_CANCEL_PROGRAM]
				| cmd[src_pkg::CMD_STOP] | cmd[src_pkg::CMD_ABORT_PROGRAM]
				| cmd[src_pkg::CMD_SERVO_OFF]);
		if (errImm)
			resumableNext = 1'b0;
		case (stateReg)
			src_pkg::ST_IDLE: begin
				if (errImm)
					stateNext = src_pkg::ST_CUT;
				else if (cmd[src_pkg::CMD_START] && !anyCause)
					stateNext = src_pkg::ST_RUN;
			end
			src_pkg::ST_RUN: begin
				if (errImm)
					stateNext = src_pkg::ST_CUT;
				else if (decelEvt)
					stateNext = src_pkg::ST_DECEL;
			end
			src_pkg::ST_DECEL: begin
				if (errImm || hwCutoff)
					stateNext = src_pkg::ST_CUT;
				else if (atRest)
					stateNext = src_pkg::ST_HOLD;
			end
			src_pkg::ST_HOLD: begin
				if (errImm || hwCutoff)
					stateNext = src_pkg::ST_CUT;
				else if (!anyCause && !resumableReg)
					stateNext = src_pkg::ST_IDLE;
				else if (!anyCause && pauseRstReq)
					stateNext = src_pkg::ST_RUN;
			end
			src_pkg::ST_CUT: begin
				// drive comes back only on request with cutoff removed
				if (drvRecReq && !hwCutoff && !errImm)
					stateNext = src_pkg::ST_HOLD;
			end
			default: stateNext = src_pkg::ST_IDLE;
		endcase
	end

	// state and continue flag
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			stateReg <= src_pkg::ST_IDLE;
			resumableReg <= 1'b0;
		end else begin
			stateReg <= stateNext;
			resumableReg <= resumableNext;
		end
	end

	// outputs follow the next state so each is a plain flop
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			decelActive <= 1'b0;
			servoOn <= 1'b0;
			drivePowerEn <= 1'b0;
			profileAbort <= 1'b0;
			opPaused <= 1'b0;
			opRunning <= 1'b0;
		end else begin
			decelActive <= stateNext == src_pkg::ST_DECEL;
			servoOn <= stateNext != src_pkg::ST_CUT;
			drivePowerEn <= stateNext != src_pkg::ST_CUT;
			// profile dropped without decelerating on any entry to cut
			profileAbort <= stateNext == src_pkg::ST_CUT
				&& stateReg != src_pkg::ST_CUT;
			opPaused <= stateNext == src_pkg::ST_HOLD;
			opRunning <= stateNext == src_pkg::ST_RUN;
		end
	end

	// last reported error code, for software diagnosis
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			lastErrReg <= 12'h000;
		else if (errValid)
			lastErrReg <= errCode;
	end

	// configuration register
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			cfgReg <= src_pkg::CFG_RESET;
		else if (accWr && paddr == src_pkg::OFS_CFG)
			cfgReg <= pwdata[7:0];
	end

	// interrupt events from state transitions
	always_comb begin
		irqEvt = 4'h0;
		irqEvt[src_pkg::IRQ_DECEL] = stateNext == src_pkg::ST_DECEL
			&& stateReg != src_pkg::ST_DECEL;
		irqEvt[src_pkg::IRQ_CUT] = stateNext == src_pkg::ST_CUT
			&& stateReg != src_pkg::ST_CUT;
		irqEvt[src_pkg::IRQ_DRV_REC] = stateReg == src_pkg::ST_CUT
			&& stateNext == src_pkg::ST_HOLD;
		irqEvt[src_pkg::IRQ_RESUMED] = stateReg == src_pkg::ST_HOLD
			&& stateNext == src_pkg::ST_RUN;
	end

	// sticky status, write one to clear; a new event beats the clear
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			irqStatReg <= 4'h0;
		else if (accWr && paddr == src_pkg::OFS_IRQ_STAT)
			irqStatReg <= (irqStatReg & ~pwdata[3:0]) | irqEvt;
		else
			irqStatReg <= irqStatReg | irqEvt;
	end

	// interrupt mask
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			irqMaskReg <= src_pkg::IRQ_MASK_RESET;
		else if (accWr && paddr == src_pkg::OFS_IRQ_MASK)
			irqMaskReg <= pwdata[3:0];
	end

	// level interrupt, one cycle behind the status bits
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			irq <= 1'b0;
		else
			irq <= |(irqStatReg & irqMaskReg);
	end

	// apb: ready in the first access cycle, data captured at setup
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel & ~penable;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			if (psel && !penable) begin
				case (paddr)
					src_pkg::OFS_CMD: prdata <= 32'h0000_0000;
					src_pkg::OFS_CFG: prdata <= {24'h000000, cfgReg};
					src_pkg::OFS_STATUS: begin
						prdata[2:0] <= stateReg;
						prdata[3] <= resumableReg;
						prdata[4] <= servoOn;
						prdata[5] <= drivePowerEn;
						prdata[src_pkg::STS_ERR_LSB +: src_pkg::ERR_W] <= lastErrReg;
					end
					src_pkg::OFS_IRQ_STAT: prdata <= {28'h0000000, irqStatReg};
					src_pkg::OFS_IRQ_MASK: prdata <= {28'h0000000, irqMaskReg};
					default: pslverr <= 1'b1;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ==== pkg/src_pkg.sv ====
// src_pkg: shared constants for the stop and recovery control block.
// assumes a 32-bit apb register bus and a 12-bit error code input.
package src_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CMD      = 8'h00;
	localparam logic [7:0] OFS_CFG      = 8'h04;
	localparam logic [7:0] OFS_STATUS   = 8'h08;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h10;

	// command register bits (write-one pulses)
	localparam int CMD_PAUSE     = 0;
	localparam int CMD_SERVO_OFF = 1;
	localparam int CMD_HOLD      = 2;
	localparam int CMD_CANCEL_PROGRAM = 3;
	localparam int CMD_STOP           = 4;
	localparam int CMD_ABORT_PROGRAM  = 5;
	localparam int CMD_DRV_REC   = 6;
	localparam int CMD_PAUSE_RST = 7;
	localparam int CMD_START     = 8;

	// configuration register fields
	localparam int CFG_P14_EN  = 0;
	localparam int CFG_P5_EN   = 1;
	localparam int CFG_P6_EN   = 2;
	localparam int CFG_EMG_LSB = 4;
	localparam int CFG_DMS_LSB = 6;
	localparam logic [7:0] CFG_RESET    = 8'h00;
	localparam logic [1:0] RECOVER_CONT = 2'h2;

	// status register field positions
	localparam int STS_ERR_LSB = 16;

	// interrupt bits
	localparam int IRQ_W        = 4;
	localparam int IRQ_DECEL    = 0;
	localparam int IRQ_CUT      = 1;
	localparam int IRQ_DRV_REC  = 2;
	localparam int IRQ_RESUMED  = 3;
	localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

	// error codes taking the immediate servo-off path
	localparam int ERR_W = 12;
	localparam int IMM_N = 13;
	localparam logic [ERR_W*IMM_N-1:0] IMM_LIST = {
		12'h614, 12'h6BB, 12'h6BC, 12'hB05, 12'hB11, 12'hC6B, 12'hC99,
		12'hCA5, 12'hCC6, 12'hD0A, 12'hD10, 12'hD15, 12'hD17};
	localparam logic [ERR_W-1:0] SYSDOWN_LO = 12'hF00;
	localparam logic [ERR_W-1:0] SYSDOWN_HI = 12'hFBF;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_RUN   = 3'b001,
		ST_DECEL = 3'b010,
		ST_HOLD  = 3'b011,
		ST_CUT   = 3'b100
	} src_state_t;
endpackage

// ==== verilog/src_edge_sync.sv ====
// src_edge_sync: two-flop synchroniser with rising-edge pulse.
// assumes one system clock; the enable gates only the pulse.
`timescale 1ns/1ps
`default_nettype none
module src_edge_sync (
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic rst_n,
	// pin side
	input  wire logic pinIn,
	input  wire logic enable,
	// outputs
	output logic      level,
	output logic      rise
);
	logic syncA;
	logic prevLvl;

	// first stage feeds only the second stage
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			syncA <= 1'b0;
			level <= 1'b0;
			prevLvl <= 1'b0;
		end else begin
			syncA <= pinIn;
			level <= syncA;
			prevLvl <= level;
		end
	end

	// one-cycle pulse on the on edge, masked when function not selected
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			rise <= 1'b0;
		else
			rise <= enable & level & ~prevLvl;
	end
endmodule
`default_nettype wire

// ==== verilog/src_err_class.sv ====
// src_err_class: sorts an incoming error code into a stop method.
// assumes errValid is a one-cycle pulse with errCode valid alongside.
`timescale 1ns/1ps
`default_nettype none
module src_err_class (
	// clock and reset
	input  wire logic                     clk_sys,
	input  wire logic                     rst_n,
	// error report
	input  wire logic                     errValid,
	input  wire logic [src_pkg::ERR_W-1:0] errCode,
	// classification, one cycle later
	output logic                          immStop,
	output logic                          decStop
);
	logic inList;

	// listed codes and the whole system-down range cut power at once
	always_comb begin
		inList = (errCode >= src_pkg::SYSDOWN_LO) && (errCode <= src_pkg::SYSDOWN_HI);
		for (int i = 0; i < src_pkg::IMM_N; i++) begin
			if (errCode == src_pkg::IMM_LIST[i*src_pkg::ERR_W +: src_pkg::ERR_W])
				inList = 1'b1;
		end
	end

	// register so the comparator tree stays off the state machine path
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			immStop <= 1'b0;
			decStop <= 1'b0;
		end else begin
			immStop <= errValid & inList;
			decStop <= errValid & ~inList;
		end
	end
endmodule
`default_nettype wire

// ==== tb/src_stop_ctrl_properties.sv ====
// src_stop_ctrl_properties: port-level timing checks of the stop block.
// assumes a bind onto src_stop_ctrl and a single clock domain.
`timescale 1ns/1ps
`default_nettype none
module src_stop_ctrl_properties (
	// clock and reset
	input wire logic                      clk_sys,
	input wire logic                      rst_n,
	// apb
	input wire logic                      psel,
	input wire logic                      penable,
	input wire logic                      pwrite,
	input wire logic                      pready,
	input wire logic [7:0]                paddr,
	input wire logic [31:0]               pwdata,
	// pins and events
	input wire logic                      inPort14,
	input wire logic                      inPort5,
	input wire logic                      hwCutoff,
	input wire logic                      errValid,
	input wire logic [src_pkg::ERR_W-1:0] errCode,
	// block outputs
	input wire logic                      decelActive,
	input wire logic                      servoOn,
	input wire logic                      drivePowerEn,
	input wire logic                      profileAbort,
	input wire logic                      opPaused,
	input wire logic                      opRunning
);
	logic [7:0] cfgSeen;
	logic       acc;
	logic       downCode;
	logic       immCode;
	// write access and error classes worked out independently of the block
	assign acc = psel && penable && pready && pwrite;
	assign downCode = errCode inside {[12'hF00:12'hFBF]};
	assign immCode = downCode || errCode inside {12'h614, 12'h6BB, 12'h6BC, 12'hB05, 12'hB11,
		12'hC6B, 12'hC99, 12'hCA5, 12'hCC6, 12'hD0A, 12'hD10, 12'hD15, 12'hD17};
	// shadow of the select bits, since the register itself is not visible here
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			cfgSeen <= 8'h00;
		else if (acc && paddr == src_pkg::OFS_CFG)
			cfgSeen <= pwdata[7:0];
	end
	default clocking dc @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	property p_decel_servo; decelActive |-> servoOn && drivePowerEn; endproperty
	a_decel_servo: assert property (p_decel_servo) else $error("servo lost in decel");
	property p_abort; profileAbort |-> !servoOn && !drivePowerEn ##1 !profileAbort; endproperty
	a_abort: assert property (p_abort) else $error("abort without cut");
	// every loss of servo must come with the profile abort pulse
	property p_abort_entry; $fell(servoOn) |-> profileAbort; endproperty
	a_abort_entry: assert property (p_abort_entry) else $error("cut without abort");
	property p_imm; errValid && immCode && opRunning |-> ##[1:3] !servoOn; endproperty
	a_imm: assert property (p_imm) else $error("listed error kept servo");
	property p_down; errValid && downCode && opRunning |-> ##[1:3] !drivePowerEn; endproperty
	a_down: assert property (p_down) else $error("system-down kept power");
	property p_soft; errValid && !immCode && opRunning |-> ##[1:3] decelActive; endproperty
	a_soft: assert property (p_soft) else $error("other error no decel");
	property p_cmd;
		acc && paddr == src_pkg::OFS_CMD && pwdata[5:0] != 6'h00 && opRunning
			|-> ##[1:2] decelActive;
	endproperty
	a_cmd: assert property (p_cmd) else $error("stop command no decel");
	property p_hw; decelActive && hwCutoff |-> ##[1:2] !servoOn; endproperty
	a_hw: assert property (p_hw) else $error("cutoff ignored in decel");
	property p_pin14; $rose(inPort14) && cfgSeen[0] && !servoOn && !hwCutoff |-> ##[2:6] servoOn; endproperty
	a_pin14: assert property (p_pin14) else $error("port 14 edge ignored");
	property p_pin14_off; $rose(inPort14) && !cfgSeen[0] && !servoOn |-> ##1 !servoOn [*6]; endproperty
	a_pin14_off: assert property (p_pin14_off) else $error("deselected port acted");
	property p_pin5; $rose(inPort5) && cfgSeen[1] && opPaused |-> ##[2:6] opRunning; endproperty
	a_pin5: assert property (p_pin5) else $error("port 5 edge ignored");
	c_abort: cover property (profileAbort);
	c_resume: cover property (opPaused ##1 opRunning);
	c_imm: cover property (errValid && immCode);
endmodule
`default_nettype wire

// ==== tb/src_op_model.sv ====
// src_op_model: operator pins, motion engine rest flag and power stage.
// assumes one-cycle requests from the bench; pins stay high four cycles.
`timescale 1ns/1ps
`default_nettype none
module src_op_model (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	// bench requests
	input  wire logic       req14,
	input  wire logic       req5,
	input  wire logic       cutReq,
	input  wire logic [3:0] stall,
	// block outputs
	input  wire logic       decelActive,
	input  wire logic       drivePowerEn,
	// far-side levels
	output logic            inPort14,
	output logic            inPort5,
	output logic            atRest,
	output logic            hwCutoff
);
	logic       pend14;
	logic       pend5;
	logic       go14;
	logic       go5;
	logic [2:0] hold14;
	logic [2:0] hold5;
	logic [3:0] restCnt;
	// recovery only once cut and the cause is gone; pause reset waits for it
	assign go14 = pend14 && !drivePowerEn && !hwCutoff && hold14 == 3'h0;
	assign go5 = pend5 && !pend14 && hold14 == 3'h0 && drivePowerEn && hold5 == 3'h0;
	assign inPort14 = hold14 != 3'h0;
	assign inPort5 = hold5 != 3'h0;
	assign atRest = decelActive && restCnt == 4'h0;
	// pending requests and pin pulse widths long enough for the synchroniser
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			{pend14, pend5, hold14, hold5} <= '0;
		end else begin
			pend14 <= req14 | (pend14 & ~go14);
			pend5 <= req5 | (pend5 & ~go5);
			hold14 <= go14 ? 3'h4 : hold14 - 3'(hold14 != 3'h0);
			hold5 <= go5 ? 3'h4 : hold5 - 3'(hold5 != 3'h0);
		end
	end
	// axis comes to rest a commanded number of cycles into a deceleration
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			restCnt <= 4'h0;
			hwCutoff <= 1'b0;
		end else begin
			restCnt <= decelActive ? restCnt - 4'(restCnt != 4'h0) : stall;
			hwCutoff <= cutReq;
		end
	end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// testbench: random and corner stimulus for the stop and recovery block.
// assumes src_pkg, the design and src_op_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk_sys = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic pready, pslverr, rerr, inPort14, inPort5, atRest, hwCutoff, irq;
	logic inPort6 = 1'b1, emgStopIn = 1'b0, deadmanOk = 1'b1, autoMode = 1'b0;
	logic errValid = 1'b0, req14 = 1'b0, req5 = 1'b0, cutReq = 1'b0;
	logic [11:0] errCode = 12'h000, code;
	logic [11:0] corner [4] = '{12'hF00, 12'hFBF, 12'hFC0, 12'hEFF};
	logic [3:0] stall = 4'h2;
	logic decelActive, servoOn, drivePowerEn, profileAbort, opPaused, opRunning;
	int errors = 0, compares = 0, seed = 32'hBA4E41E3, i, r;
	localparam int SV = 0, DC = 1, RN = 2, PS = 3, IQ = 4;
	wire logic [4:0] obs;
	assign obs = {irq, opPaused, opRunning, decelActive, servoOn};
	always #25 clk_sys = ~clk_sys;
	src_stop_ctrl dut (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
		.pslverr, .prdata, .inPort14, .inPort5, .inPort6, .emgStopIn, .deadmanOk, .autoMode,
		.atRest, .hwCutoff, .errValid, .errCode, .decelActive, .servoOn, .drivePowerEn,
		.profileAbort, .opPaused, .opRunning, .irq);
	src_op_model u_op (.clk_sys, .rst_n, .req14, .req5, .cutReq, .stall, .decelActive,
		.drivePowerEn, .inPort14, .inPort5, .atRest, .hwCutoff);
	task automatic tally_and_finish;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	// bounded wait on one watched output
	task automatic wait_obs(input int k, input logic v);
		int n;
		for (n = 0; n < 400 && obs[k] !== v; n++)
			@(posedge clk_sys);
		chk_bit(obs[k], v);
		if (n == 400)
			tally_and_finish;
	endtask
	// one apb transfer; the leading edge keeps back-to-back calls race free
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rdat = prdata;
		rerr = pslverr;
		{psel, penable} <= 2'b00;
		if (n == 20) begin
			errors++;
			tally_and_finish;
		end
	endtask
	task automatic cmd(input int b);
		apb(1'b1, src_pkg::OFS_CMD, 32'h1 << b);
	endtask
	task automatic start_run;
		if (opRunning !== 1'b1) begin
			cmd(src_pkg::CMD_START);
			wait_obs(RN, 1'b1);
		end
	endtask
	task automatic raise_err(input logic [11:0] c);
		{errCode, errValid} <= {c, 1'b1};
		@(posedge clk_sys);
		errValid <= 1'b0;
	endtask
	task automatic resume(input logic viaPin);
		if (viaPin)
			req5 <= 1'b1;
		else
			cmd(src_pkg::CMD_PAUSE_RST);
		@(posedge clk_sys);
		req5 <= 1'b0;
		wait_obs(RN, 1'b1);
	endtask
	function automatic logic is_imm(input logic [11:0] c);
		int k;
		is_imm = c >= 12'hF00 && c <= 12'hFBF;
		for (k = 0; k < src_pkg::IMM_N; k++)
			if (src_pkg::IMM_LIST[k*12 +: 12] == c)
				is_imm = 1'b1;
	endfunction
	initial begin
		repeat (100000) @(posedge clk_sys);
		errors++;
		tally_and_finish;
	end
	initial begin
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		// reset values, status and an unmapped place
		apb(1'b0, src_pkg::OFS_CFG, 32'h0);
		chk_word(rdat, {24'h0, src_pkg::CFG_RESET});
		apb(1'b0, src_pkg::OFS_IRQ_MASK, 32'h0);
		chk_word(rdat, {28'h0, src_pkg::IRQ_MASK_RESET});
		apb(1'b0, src_pkg::OFS_STATUS, 32'h0);
		chk_word(rdat, 32'h30);
		apb(1'b1, 8'h40, 32'hFF);
		chk_bit(rerr, 1'b1);
		apb(1'b1, src_pkg::OFS_CFG, 32'hA7);
		apb(1'b0, src_pkg::OFS_CFG, 32'h0);
		chk_word(rdat, 32'hA7);
		// every stop command; only pause and hold may be resumed
		for (i = src_pkg::CMD_PAUSE; i <= src_pkg::CMD_ABORT_PROGRAM; i++) begin
			start_run();
			stall <= 4'($random(seed));
			cmd(i);
			wait_obs(DC, 1'b1);
			wait_obs(DC, 1'b0);
			repeat (3) @(posedge clk_sys);
			chk_bit(opPaused, i == src_pkg::CMD_PAUSE || i == src_pkg::CMD_HOLD);
			if (opPaused === 1'b1)
				resume(1'($random(seed)));
		end
		// random and boundary error codes, both recovery routes
		for (i = 0; i < 16; i++) begin
			start_run();
			r = $random(seed);
			code = r[0] ? src_pkg::IMM_LIST[(r[7:4] % 13)*12 +: 12] : {r[1] ? 4'hF : r[11:8], r[15:8]};
			if (i < 4)
				code = corner[i];
			autoMode <= r[20];
			raise_err(code);
			if (is_imm(code)) begin
				wait_obs(SV, 1'b0);
				chk_bit(drivePowerEn, 1'b0);
				if (r[16])
					req14 <= 1'b1;
				else
					cmd(src_pkg::CMD_DRV_REC);
				@(posedge clk_sys);
				req14 <= 1'b0;
				wait_obs(SV, 1'b1);
			end else begin
				wait_obs(DC, 1'b1);
				wait_obs(DC, 1'b0);
			end
		end
		// deselected port 14 leaves the drive cut
		apb(1'b1, src_pkg::OFS_CFG, 32'hA6);
		start_run();
		raise_err(12'hD17);
		wait_obs(SV, 1'b0);
		req14 <= 1'b1;
		@(posedge clk_sys);
		req14 <= 1'b0;
		repeat (12) @(posedge clk_sys);
		chk_bit(servoOn, 1'b0);
		cmd(src_pkg::CMD_DRV_REC);
		wait_obs(SV, 1'b1);
		apb(1'b1, src_pkg::OFS_CFG, 32'hA7);
		// emergency in automatic operation, then both recoveries at once
		{autoMode, stall} <= {1'b1, 4'hF};
		start_run();
		emgStopIn <= 1'b1;
		wait_obs(DC, 1'b1);
		cutReq <= 1'b1;
		wait_obs(SV, 1'b0);
		{emgStopIn, cutReq, req14, req5} <= 4'b0011;
		@(posedge clk_sys);
		{req14, req5} <= 2'b00;
		wait_obs(SV, 1'b1);
		wait_obs(RN, 1'b1);
		// emergency with the stop-only type: after recovery the axis stays idle
		apb(1'b1, src_pkg::OFS_CFG, 32'h87);
		emgStopIn <= 1'b1;
		wait_obs(DC, 1'b1);
		cutReq <= 1'b1;
		wait_obs(SV, 1'b0);
		{emgStopIn, cutReq, req14} <= 3'b001;
		@(posedge clk_sys);
		req14 <= 1'b0;
		wait_obs(SV, 1'b1);
		repeat (4) @(posedge clk_sys);
		chk_bit(opRunning | opPaused, 1'b0);
		apb(1'b1, src_pkg::OFS_CFG, 32'hA7);
		// port 6 pause, then deadman stop, each needing a pause reset
		for (i = 0; i < 2; i++) begin
			start_run();
			{deadmanOk, inPort6} <= i ? 2'b01 : 2'b10;
			wait_obs(PS, 1'b1);
			{deadmanOk, inPort6} <= 2'b11;
			repeat (8) @(posedge clk_sys);
			chk_bit(opPaused, 1'b1);
			resume(1'b1);
		end
		// interrupt masked, unmasked, then cleared by writing ones
		apb(1'b0, src_pkg::OFS_IRQ_STAT, 32'h0);
		chk_word(rdat, 32'hF);
		chk_bit(irq, 1'b0);
		apb(1'b1, src_pkg::OFS_IRQ_MASK, 32'h2);
		wait_obs(IQ, 1'b1);
		apb(1'b1, src_pkg::OFS_IRQ_STAT, 32'hF);
		wait_obs(IQ, 1'b0);
		tally_and_finish;
	end
endmodule
bind src_stop_ctrl src_stop_ctrl_properties u_props (.*);
`default_nettype wire
